// *** sim/nvsc_dev_model.sv ***
// partner: behavioural byte-wide nvsram, 256 cells aliased over the address
// assumes: pins sampled on core_clk_i; rst_i stands for a power-up
`timescale 1ns/1ps
module nvsc_dev_model #(
   parameter int BUSY_CYC = 40
) (
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic        sel_i,
   input  wire logic        oe_n_i,
   input  wire logic        we_n_i,
   input  wire logic [20:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic        busy_n_i,
   output logic [7:0]       dq_o,
   output logic             busy_low_o
);
   localparam logic [15:0] LEAD [5] = '{16'h4E38, 16'hB1C7, 16'h83E0, 16'h7C1F, 16'h703F};
   localparam logic [15:0] LAST [4] = '{16'h8FC0, 16'h4C63, 16'h8B45, 16'h4B46};
   logic [7:0] mem [256] = '{default: 8'h00};
   logic [7:0] nv [256] = '{default: 8'h00};
   logic [7:0] last_reg = 8'h00;
   logic       sel_reg, wr_reg, rd, fin, do_st, do_rc;
   logic       latch_reg = 1'b0;
   logic       pls_reg = 1'b1;
   int         cnt, step;
   int         stores = 0;
   // data driven only on a live read, else the inverse of the last value
   assign rd = sel_i && !oe_n_i && we_n_i && busy_n_i && cnt == 0;
   assign dq_o = rd ? mem[addr_i[7:0]] : ~last_reg;
   assign busy_low_o = cnt > 0;
   // sixth read seen, plus the store and recall triggers
   assign fin = sel_reg && !sel_i && !wr_reg && step == 5;
   assign do_st = (!busy_n_i && cnt == 0 && latch_reg)
                  || (fin && addr_i[14:2] == LAST[0][14:2]);
   assign do_rc = fin && addr_i[14:2] == LAST[1][14:2];
   // power-up recall, accesses, sequence steps, busy timing
   always @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt <= BUSY_CYC;
         if (pls_reg && latch_reg) nv <= mem;
         else mem <= nv;
         latch_reg <= 1'b0;
         step <= 0;
         sel_reg <= 1'b0;
         wr_reg <= 1'b0;
      end else begin
         sel_reg <= sel_i;
         wr_reg <= sel_i && !we_n_i && busy_n_i && cnt == 0;
         if (rd) begin
            last_reg <= dq_o;
         end
         if (cnt > 0) begin
            cnt <= cnt - 1;
         end
         if (sel_reg && !sel_i) begin
            step <= (step < 5 && !wr_reg && addr_i[14:2] == LEAD[step][14:2]) ? step + 1
                    : 0;
         end
         if (sel_reg && !sel_i && wr_reg) begin
            mem[addr_i[7:0]] <= wdata_i;
            latch_reg <= 1'b1;
         end
         if (fin && addr_i[14:2] == LAST[2][14:2]) begin
            pls_reg <= 1'b0;
         end
         if (fin && addr_i[14:2] == LAST[3][14:2]) begin
            pls_reg <= 1'b1;
         end
         if (do_st || do_rc) begin
            cnt <= BUSY_CYC;
            latch_reg <= 1'b0;
         end
         if (do_st) begin
            stores <= stores + 1;
            nv <= mem;
         end
         if (do_rc) begin
            mem <= nv;
         end
      end
   end
endmodule

// *** sim/tb_top.sv ***
// bench: host controller against the behavioural nvsram partner
// assumes: byte-wide organisation and a shortened power-up recall
`timescale 1ns/1ps
module tb_top;
   typedef struct {nvsc_pkg::nvsc_op_t op; logic [20:0] a; logic [7:0] d;} nvsc_row_t;
   logic               core_clk_i = 1'b0;
   logic               rst_i = 1'b1;
   logic               cmd_valid_i = 1'b0;
   nvsc_pkg::nvsc_op_t cmd_op_i = nvsc_pkg::OP_READ;
   logic [20:0]        cmd_addr_i = '0;
   logic [7:0]         cmd_wdata_i = '0;
   logic               ready, done, rvalid, csl, csh, oe_n, we_n, slp, dq_oe, bn_o, b_oe;
   logic               busy_n, dev_low;
   logic [0:0]         be_n;
   logic [20:0]        addr;
   logic [7:0]         rdata, dq_dev, dq_host, dq_line;
   int                 bad_count = 0;
   int                 cmp_count = 0;
   nvsc_row_t          rows [5] = '{'{nvsc_pkg::OP_WRITE, 21'h10, 8'hA5},
      '{nvsc_pkg::OP_WRITE, 21'hFF, 8'h5A}, '{nvsc_pkg::OP_READ, 21'h10, 8'hA5},
      '{nvsc_pkg::OP_READ, 21'hFF, 8'h5A}, '{nvsc_pkg::OP_READ, 21'h00, 8'h00}};
   // clock and the resolved data and busy lines
   always #2.5 core_clk_i = ~core_clk_i;
   assign dq_line = dq_oe ? dq_host : dq_dev;
   assign busy_n = (b_oe ? bn_o : 1'b1) && !dev_low;
   nvsc_host_ctrl #(.DATA_W(8), .ADDR_W(21), .RECALL_CYC(20)) i_nvsc_host_ctrl (
      .core_clk_i, .rst_i, .cmd_valid_i, .cmd_op_i, .cmd_addr_i, .cmd_wdata_i,
      .cmd_be_n_i(1'b0), .cmd_ready_o(ready), .done_o(done), .rdata_valid_o(rvalid),
      .rdata_o(rdata), .chip_select_low_active_o(csl), .chip_select_high_active_o(csh),
      .output_enable_n_o(oe_n), .write_enable_n_o(we_n), .byte_enable_n_o(be_n),
      .sleep_request_n_o(slp), .addr_o(addr), .dq_i(dq_line), .dq_o(dq_host),
      .dq_oe_o(dq_oe), .store_busy_n_i(busy_n), .store_busy_n_o(bn_o), .store_busy_oe_o(b_oe));
   nvsc_dev_model i_nvsc_dev_model (.core_clk_i, .rst_i, .sel_i(!csl && csh && slp),
      .oe_n_i(oe_n | be_n[0]), .we_n_i(we_n), .addr_i(addr), .wdata_i(dq_line),
      .busy_n_i(busy_n), .dq_o(dq_dev), .busy_low_o(dev_low));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic run(input nvsc_pkg::nvsc_op_t op, input logic [20:0] a, input logic [7:0] d);
      int n;
      n = 0;
      while (ready !== 1'b1 && n < 3000) begin
         @(negedge core_clk_i);
         n++;
      end
      cmd_valid_i = 1'b1;
      cmd_op_i = op;
      cmd_addr_i = a;
      cmd_wdata_i = d;
      @(negedge core_clk_i);
      cmd_valid_i = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 3000) begin
         @(negedge core_clk_i);
         n++;
      end
      check(8'(done), 8'h01);
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // table of accesses, then stores, recalls, modes, second reset
   initial begin
      repeat (20) @(negedge core_clk_i);
      rst_i = 1'b0;
      foreach (rows[i]) begin
         run(rows[i].op, rows[i].a, rows[i].d);
         if (rows[i].op == nvsc_pkg::OP_READ) check(rdata, rows[i].d);
      end
      $display("table rows done");
      run(nvsc_pkg::OP_SW_STORE, 21'h0, 8'h00);
      check(8'(i_nvsc_dev_model.stores), 8'h01);
      run(nvsc_pkg::OP_WRITE, 21'h10, 8'h77);
      run(nvsc_pkg::OP_SW_RECALL, 21'h0, 8'h00);
      run(nvsc_pkg::OP_READ, 21'h10, 8'h00);
      check(rdata, 8'hA5);
      $display("software store and recall done");
      run(nvsc_pkg::OP_HW_STORE, 21'h0, 8'h00);
      check(8'(i_nvsc_dev_model.stores), 8'h01);
      run(nvsc_pkg::OP_WRITE, 21'h20, 8'h3C);
      run(nvsc_pkg::OP_HW_STORE, 21'h0, 8'h00);
      check(8'(i_nvsc_dev_model.stores), 8'h02);
      run(nvsc_pkg::OP_PLS_OFF, 21'h0, 8'h00);
      check(8'(i_nvsc_dev_model.pls_reg), 8'h00);
      run(nvsc_pkg::OP_PLS_ON, 21'h0, 8'h00);
      check(8'(i_nvsc_dev_model.pls_reg), 8'h01);
      $display("pin store and mode sequences done");
      run(nvsc_pkg::OP_WRITE, 21'h30, 8'h3C);
      rst_i = 1'b1;
      @(negedge core_clk_i);
      check({5'h00, ready, csl, we_n}, 8'h03);
      rst_i = 1'b0;
      run(nvsc_pkg::OP_READ, 21'h30, 8'h00);
      check({rvalid, rdata[6:0]}, 8'hBC);
      $display("second reset done");
      finish_test();
   end
   // watchdog well past the expected run
   initial begin
      #200000;
      bad_count++;
      finish_test();
   end
endmodule

// *** src/nvsc_busy_if.sv ***
// interface: busy-line status from the monitor to the controller
// assumes: both ends run on core_clk_i
`timescale 1ns/1ps
interface nvsc_busy_if;
   logic busy;   // store_busy_n seen low
   logic ok;     // line high and recovery time elapsed
   modport mon (output busy, output ok);
   modport ctl (input busy, input ok);
endinterface

// *** src/nvsc_busy_mon.sv ***
// module: watches the store-busy line and times recall and recovery blocking
// assumes: store_busy_n_i is synchronous to core_clk_i
`timescale 1ns/1ps
module nvsc_busy_mon #(
   parameter int RECALL_CYC  = 4000,
   parameter int RECOVER_CYC = 200
) (
   input  wire logic core_clk_i,
   input  wire logic rst_i,
   input  wire logic store_busy_n_i,
   nvsc_busy_if.mon  bus
);
   localparam int CW = 20;
   if (RECALL_CYC >= (1 << CW) || RECOVER_CYC >= (1 << CW) || RECOVER_CYC < 1) begin : g_chk
      $error("nvsc_busy_mon: counts out of range");
   end

   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic          busy_reg;
   logic          busy_next;
   logic          ok_reg;
   logic          ok_next;

   ////////////////////////////////////////////////////////////////////////////////
   // recovery counter: restarts while busy is low, runs down after release
   always_comb begin
      busy_next = ~store_busy_n_i;
      cnt_next  = cnt_reg;
      if (!store_busy_n_i) begin
         cnt_next = CW'(RECOVER_CYC);                       // RULE_16
      end else if (cnt_reg != '0) begin
         cnt_next = cnt_reg - CW'(1);
      end
      ok_next = store_busy_n_i && (cnt_next == '0);         // RULE_14
   end

   // reset starts with the power-up recall window
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_reg  <= CW'(RECALL_CYC);                       // RULE_17
         busy_reg <= 1'b0;
         ok_reg   <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         busy_reg <= busy_next;
         ok_reg   <= ok_next;
      end
   end

   assign bus.busy = busy_reg;
   assign bus.ok   = ok_reg;

   ////////////////////////////////////////////////////////////////////////////////
   busy_blocks_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_14
      !store_busy_n_i |=> !ok_reg && busy_reg)
      else $error("access allowed while busy low");
   recovery_load_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_16
      $past(!store_busy_n_i) && store_busy_n_i |=> cnt_reg == CW'(RECOVER_CYC - 1) && !ok_reg)
      else $error("recovery time not started on busy release");
endmodule

// *** src/nvsc_host_ctrl.sv ***
// module: host-side controller driving an asynchronous nonvolatile sram through its pins
// assumes: device pins sampled and driven on core_clk_i; busy pin is open drain with pull-up
`timescale 1ns/1ps
module nvsc_host_ctrl #(
   parameter int DATA_W      = 8,
   parameter int ADDR_W      = 21,
   parameter int RECALL_CYC  = nvsc_pkg::nvsc_cycles(nvsc_pkg::RECALL_NS)
) (
   input  wire logic                 core_clk_i,
   input  wire logic                 rst_i,
   // user command port
   input  wire logic                 cmd_valid_i,
   input  wire nvsc_pkg::nvsc_op_t   cmd_op_i,
   input  wire logic [ADDR_W-1:0]    cmd_addr_i,
   input  wire logic [DATA_W-1:0]    cmd_wdata_i,
   input  wire logic [DATA_W/8-1:0]  cmd_be_n_i,
   output logic                      cmd_ready_o,
   output logic                      done_o,
   output logic                      rdata_valid_o,
   output logic [DATA_W-1:0]         rdata_o,
   // device pins
   output logic                      chip_select_low_active_o,
   output logic                      chip_select_high_active_o,
   output logic                      output_enable_n_o,
   output logic                      write_enable_n_o,
   output logic [DATA_W/8-1:0]       byte_enable_n_o,
   output logic                      sleep_request_n_o,
   output logic [ADDR_W-1:0]         addr_o,
   input  wire logic [DATA_W-1:0]    dq_i,
   output logic [DATA_W-1:0]         dq_o,
   output logic                      dq_oe_o,
   input  wire logic                 store_busy_n_i,
   output logic                      store_busy_n_o,
   output logic                      store_busy_oe_o
);
   localparam int LANES         = DATA_W / 8;
   localparam int ACCESS_CYC    = nvsc_pkg::nvsc_cycles(nvsc_pkg::ACCESS_NS);
   localparam int PULL_CYC      = nvsc_pkg::nvsc_cycles(nvsc_pkg::PULL_NS);
   localparam int BUSY_WAIT_CYC = nvsc_pkg::nvsc_cycles(nvsc_pkg::BUSY_WAIT_NS);
   localparam int RECOVER_CYC   = nvsc_pkg::nvsc_cycles(nvsc_pkg::RECOVERY_NS);
   localparam int CW            = 16;

   // organisation must match the 16-Mbit array
   if (!(DATA_W == 8 || DATA_W == 16 || DATA_W == 32) ||
       ADDR_W != 21 - $clog2(LANES) || ACCESS_CYC >= (1 << CW) ||
       BUSY_WAIT_CYC >= (1 << CW)) begin : g_chk
      $error("nvsc_host_ctrl: unsupported organisation or timing");          // RULE_02
   end

   nvsc_busy_if busy ();

   // busy-line monitor
   nvsc_busy_mon #(
      .RECALL_CYC  (RECALL_CYC),
      .RECOVER_CYC (RECOVER_CYC)
   ) u_mon (
      .core_clk_i     (core_clk_i),
      .rst_i          (rst_i),
      .store_busy_n_i (store_busy_n_i),
      .bus            (busy.mon)
   );

   nvsc_pkg::nvsc_state_t state_reg, state_next;
   nvsc_pkg::nvsc_op_t    op_reg, op_next;
   logic [ADDR_W-1:0]     uaddr_reg, uaddr_next;
   logic [DATA_W-1:0]     wdata_reg, wdata_next;
   logic [LANES-1:0]      be_reg, be_next;
   logic [2:0]            step_reg, step_next;
   logic [CW-1:0]         cnt_reg, cnt_next;
   logic                  cs_low_reg, cs_low_next;
   logic                  cs_high_reg, cs_high_next;
   logic                  oe_n_reg, oe_n_next;
   logic                  we_n_reg, we_n_next;
   logic [LANES-1:0]      pin_be_reg, pin_be_next;
   logic [ADDR_W-1:0]     pin_addr_reg, pin_addr_next;
   logic [DATA_W-1:0]     dq_reg, dq_next;
   logic                  dq_oe_reg, dq_oe_next;
   logic                  hsb_oe_reg, hsb_oe_next;
   logic [DATA_W-1:0]     rdata_reg, rdata_next;
   logic                  done_reg, done_next;
   logic                  rvalid_reg, rvalid_next;
   logic                  ready_reg, ready_next;

   // sequence address placed on the low address lines, upper lines zero
   function automatic logic [ADDR_W-1:0] seq_pin(input nvsc_pkg::nvsc_op_t op,
                                                 input logic [2:0] step);
      return {{(ADDR_W - nvsc_pkg::SEQ_ADDR_W){1'b0}}, nvsc_pkg::nvsc_seq_addr(op, step)};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // next-state and pin values
   always_comb begin
      state_next    = state_reg;
      op_next       = op_reg;
      uaddr_next    = uaddr_reg;
      wdata_next    = wdata_reg;
      be_next       = be_reg;
      step_next     = step_reg;
      cnt_next      = cnt_reg;
      cs_low_next   = cs_low_reg;
      cs_high_next  = cs_high_reg;
      oe_n_next     = oe_n_reg;
      we_n_next     = we_n_reg;
      pin_be_next   = pin_be_reg;
      pin_addr_next = pin_addr_reg;
      dq_next       = dq_reg;
      dq_oe_next    = dq_oe_reg;
      hsb_oe_next   = hsb_oe_reg;
      rdata_next    = rdata_reg;
      done_next     = 1'b0;
      rvalid_next   = 1'b0;
      case (state_reg)
         nvsc_pkg::S_IDLE: begin
            if (ready_reg && cmd_valid_i) begin
               op_next    = cmd_op_i;
               uaddr_next = cmd_addr_i;
               wdata_next = cmd_wdata_i;
               be_next    = cmd_be_n_i;
               step_next  = '0;
               if (cmd_op_i == nvsc_pkg::OP_HW_STORE) begin
                  hsb_oe_next = 1'b1;                                   // RULE_11
                  cnt_next    = CW'(PULL_CYC);
                  state_next  = nvsc_pkg::S_PULL;
               end else begin
                  pin_addr_next = nvsc_pkg::nvsc_is_seq(cmd_op_i) ?
                                  seq_pin(cmd_op_i, 3'h0) : cmd_addr_i;   // RULE_18
                  state_next    = nvsc_pkg::S_SETUP;
               end
            end
         end
         nvsc_pkg::S_SETUP: begin
            // address settles a cycle before select; wait out any busy or recovery
            if (busy.ok) begin                                          // RULE_16
               cs_low_next  = 1'b0;                                     // RULE_25
               cs_high_next = 1'b1;
               cnt_next     = CW'(ACCESS_CYC);
               state_next   = nvsc_pkg::S_ACT;
               if (op_reg == nvsc_pkg::OP_WRITE) begin
                  we_n_next   = 1'b0;                                   // RULE_05
                  dq_next     = wdata_reg;
                  dq_oe_next  = 1'b1;
                  pin_be_next = be_reg;                                 // RULE_06
               end else begin
                  oe_n_next   = 1'b0;                                   // RULE_01
                  pin_be_next = nvsc_pkg::nvsc_is_seq(op_reg) ? '0 : be_reg; // RULE_03
               end
            end
         end
         nvsc_pkg::S_ACT: begin
            if (cnt_reg == CW'(1)) begin
               cs_low_next  = 1'b1;
               cs_high_next = 1'b0;
               we_n_next    = 1'b1;
               oe_n_next    = 1'b1;
               if (op_reg != nvsc_pkg::OP_WRITE) rdata_next = dq_i;
               state_next   = nvsc_pkg::S_HOLD;
            end else begin
               cnt_next = cnt_reg - CW'(1);
            end
         end
         nvsc_pkg::S_HOLD: begin
            // address still held while select goes inactive
            dq_oe_next  = 1'b0;
            pin_be_next = '1;
            if (nvsc_pkg::nvsc_is_seq(op_reg) && step_reg != nvsc_pkg::SEQ_LAST) begin
               step_next     = step_reg + 3'h1;                         // RULE_20
               pin_addr_next = seq_pin(op_reg, step_reg + 3'h1);        // RULE_19
               state_next    = nvsc_pkg::S_SETUP;
            end else if (nvsc_pkg::nvsc_is_seq(op_reg)) begin
               cnt_next   = CW'(BUSY_WAIT_CYC);                         // RULE_21
               state_next = nvsc_pkg::S_WAITB;
            end else begin
               done_next   = 1'b1;
               rvalid_next = (op_reg == nvsc_pkg::OP_READ);
               state_next  = nvsc_pkg::S_IDLE;
            end
         end
         nvsc_pkg::S_PULL: begin
            if (cnt_reg == CW'(1)) begin
               hsb_oe_next = 1'b0;                                      // RULE_15
               cnt_next    = CW'(BUSY_WAIT_CYC);
               state_next  = nvsc_pkg::S_WAITB;
            end else begin
               cnt_next = cnt_reg - CW'(1);
            end
         end
         nvsc_pkg::S_WAITB: begin
            // give the device time to take the line, then wait for release
            if (cnt_reg != '0) begin
               cnt_next = cnt_reg - CW'(1);
            end else if (busy.ok) begin                                 // RULE_12
               done_next  = 1'b1;
               state_next = nvsc_pkg::S_IDLE;
            end
         end
         default: state_next = nvsc_pkg::S_IDLE;
      endcase
      ready_next = (state_next == nvsc_pkg::S_IDLE) && busy.ok && !done_next;
   end

   // registers
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg    <= nvsc_pkg::S_IDLE;
         op_reg       <= nvsc_pkg::OP_READ;
         uaddr_reg    <= '0;
         wdata_reg    <= '0;
         be_reg       <= '1;
         step_reg     <= '0;
         cnt_reg      <= '0;
         cs_low_reg   <= 1'b1;
         cs_high_reg  <= 1'b0;
         oe_n_reg     <= 1'b1;
         we_n_reg     <= 1'b1;
         pin_be_reg   <= '1;
         pin_addr_reg <= '0;
         dq_reg       <= '0;
         dq_oe_reg    <= 1'b0;
         hsb_oe_reg   <= 1'b0;
         rdata_reg    <= '0;
         done_reg     <= 1'b0;
         rvalid_reg   <= 1'b0;
         ready_reg    <= 1'b0;
      end else begin
         state_reg    <= state_next;
         op_reg       <= op_next;
         uaddr_reg    <= uaddr_next;
         wdata_reg    <= wdata_next;
         be_reg       <= be_next;
         step_reg     <= step_next;
         cnt_reg      <= cnt_next;
         cs_low_reg   <= cs_low_next;
         cs_high_reg  <= cs_high_next;
         oe_n_reg     <= oe_n_next;
         we_n_reg     <= we_n_next;
         pin_be_reg   <= pin_be_next;
         pin_addr_reg <= pin_addr_next;
         dq_reg       <= dq_next;
         dq_oe_reg    <= dq_oe_next;
         hsb_oe_reg   <= hsb_oe_next;
         rdata_reg    <= rdata_next;
         done_reg     <= done_next;
         rvalid_reg   <= rvalid_next;
         ready_reg    <= ready_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs straight from flip-flops, except the sleep request and busy drive value, which are tied constants
   assign cmd_ready_o               = ready_reg;
   assign done_o                    = done_reg;
   assign rdata_valid_o             = rvalid_reg;
   assign rdata_o                   = rdata_reg;
   assign chip_select_low_active_o  = cs_low_reg;
   assign chip_select_high_active_o = cs_high_reg;
   assign output_enable_n_o         = oe_n_reg;
   assign write_enable_n_o          = we_n_reg;
   assign byte_enable_n_o           = pin_be_reg;
   assign sleep_request_n_o         = 1'b1;           // sleep never requested
   assign addr_o                    = pin_addr_reg;
   assign dq_o                      = dq_reg;
   assign dq_oe_o                   = dq_oe_reg;
   assign store_busy_n_o            = 1'b0;           // open drain: only ever pulls low
   assign store_busy_oe_o           = hsb_oe_reg;

   ////////////////////////////////////////////////////////////////////////////////
   oe_write_high_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_07
      !we_n_reg |-> oe_n_reg && dq_oe_reg)
      else $error("output enable low during write");
   write_addr_stable_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_05
      !we_n_reg && $past(!we_n_reg) |-> $stable(pin_addr_reg) && !cs_low_reg)
      else $error("address moved during write");
   seq_we_high_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_21
      nvsc_pkg::nvsc_is_seq(op_reg) && state_reg == nvsc_pkg::S_ACT |-> we_n_reg && !oe_n_reg)
      else $error("write enable low inside sequence");
   seq_addr_order_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_18
      nvsc_pkg::nvsc_is_seq(op_reg) && state_reg == nvsc_pkg::S_ACT
      |-> pin_addr_reg == seq_pin(op_reg, step_reg))
      else $error("sequence address out of order");
   write_lanes_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_06
      $fell(we_n_reg) |-> pin_be_reg == be_reg && dq_reg == wdata_reg)
      else $error("write lanes differ from request");
   dual_select_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_25
      cs_low_reg == !cs_high_reg)
      else $error("select pair inconsistent");
   busy_pull_len_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_15
      $rose(hsb_oe_reg) |-> hsb_oe_reg [*2] ##[0:60] !hsb_oe_reg)
      else $error("busy pull not released in time");
   select_when_free_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_14
      $fell(cs_low_reg) |-> $past(busy.ok && !busy.busy) && $past(state_reg) == nvsc_pkg::S_SETUP)
      else $error("access started while blocked");
   read_capture_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // RULE_04
      rvalid_reg |-> $past(state_reg) == nvsc_pkg::S_HOLD && done_reg)
      else $error("read data flagged without a read");
endmodule

// *** src/nvsc_pkg.sv ***
// package: constants, types and helpers for the nvsram host controller
// assumes: a 200 MHz core clock and a device strapped for the organisation chosen at the top
// Summary of operation
// (RULE_01) Device reads while selected, output enabled, write high, sleep and busy high.
// (RULE_02) Address picks one byte, halfword or word of the 16-Mbit array.
// (RULE_03) On wide parts, reads drive only lanes whose low-active byte enables are low.
// (RULE_04) A held read follows address changes until a control ends it.
// (RULE_05) Write while selected, write low, busy high; host holds address stable throughout.
// (RULE_06) On wide parts, writes update only lanes whose byte enables are low.
// (RULE_07) Host keeps output enable high during writes; device turns drivers off anyway.
// (RULE_08) Store triggers: busy pin, software sequence, power loss; power-loss store on by default.
// (RULE_09) Below switch threshold the device isolates its capacitor and stores from it.
// (RULE_10) Pin and power-loss stores need the write latch; software stores always run.
// (RULE_11) Busy pulled low starts a store after a delay if the write latch is set.
// (RULE_12) Device holds busy low for the whole of every store.
// (RULE_13) After pin or software store device drives busy high briefly, then weak pull-up.
// (RULE_14) Writes requested after busy falls are blocked until busy returns high.
// (RULE_15) With latch clear the device leaves busy; access blocked until the host releases it.
// (RULE_16) After a store, access stays blocked a recovery time after busy rises.
// (RULE_17) Power-up or supply dip latches a recall; busy low and access blocked meanwhile.
// (RULE_18) Software store: read the five lead addresses then the store address, in order.
// (RULE_19) Software recall: read the same five lead addresses then the recall address.
// (RULE_20) Any other access inside a sequence abandons it with no store or recall.
// (RULE_21) Sequence reads keep write high; after the sixth the device goes busy.
// (RULE_22) Recall clears the array, copies nonvolatile data in, then access resumes.
// (RULE_23) Only address bits 14 to 2 are decoded for the sequences.
// (RULE_24) Sequences ending at the two mode addresses switch the power-loss store off or on.
// (RULE_25) With two selects, the part is selected only when low-active low, high-active high.
// (RULE_26) Any write sets the write latch; any store or recall clears it.
package nvsc_pkg;

   localparam int CLK_PS          = 5000;   // core clock period
   localparam int PS_PER_NS       = 1000;
   localparam int ACCESS_NS       = 50;     // select-to-data and write pulse width
   localparam int PULL_NS         = 100;    // how long the host pulls busy low
   localparam int BUSY_WAIT_NS    = 1000;   // time given the device to grab busy
   localparam int RECOVERY_NS     = 1000;   // post_store_recovery
   localparam int RECALL_NS       = 20000;  // powerup_recall_time
   localparam int SEQ_ADDR_W      = 16;
   localparam logic [2:0] SEQ_LAST = 3'h5;

   localparam logic [15:0] SEQ_ADDR_1      = 16'h4E38;
   localparam logic [15:0] SEQ_ADDR_2      = 16'hB1C7;
   localparam logic [15:0] SEQ_ADDR_3      = 16'h83E0;
   localparam logic [15:0] SEQ_ADDR_4      = 16'h7C1F;
   localparam logic [15:0] SEQ_ADDR_5      = 16'h703F;
   localparam logic [15:0] SEQ_STORE_ADDR  = 16'h8FC0;
   localparam logic [15:0] SEQ_RECALL_ADDR = 16'h4C63;
   localparam logic [15:0] SEQ_PLS_OFF     = 16'h8B45;
   localparam logic [15:0] SEQ_PLS_ON      = 16'h4B46;

   typedef enum logic [2:0] {
      OP_READ      = 3'b000,
      OP_WRITE     = 3'b001,
      OP_SW_STORE  = 3'b010,
      OP_SW_RECALL = 3'b011,
      OP_PLS_OFF   = 3'b100,
      OP_PLS_ON    = 3'b101,
      OP_HW_STORE  = 3'b110
   } nvsc_op_t;

   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_SETUP = 3'b001,
      S_ACT   = 3'b010,
      S_HOLD  = 3'b011,
      S_PULL  = 3'b100,
      S_WAITB = 3'b101
   } nvsc_state_t;

   // least time in ns to whole clock cycles, never below one
   function automatic int nvsc_cycles(input int ns);
      int c;
      c = (ns * PS_PER_NS + CLK_PS - 1) / CLK_PS;
      return (c < 1) ? 1 : c;
   endfunction

   // true for the six-read software operations
   function automatic logic nvsc_is_seq(input nvsc_op_t op);
      return (op == OP_SW_STORE) || (op == OP_SW_RECALL) || (op == OP_PLS_OFF) ||
             (op == OP_PLS_ON);
   endfunction

   // address of a given step of a software sequence
   function automatic logic [15:0] nvsc_seq_addr(input nvsc_op_t op, input logic [2:0] step);
      logic [15:0] a;
      a = SEQ_ADDR_1;
      case (step)
         3'h0: a = SEQ_ADDR_1;
         3'h1: a = SEQ_ADDR_2;
         3'h2: a = SEQ_ADDR_3;
         3'h3: a = SEQ_ADDR_4;
         3'h4: a = SEQ_ADDR_5;
         default: begin
            if (op == OP_SW_STORE) a = SEQ_STORE_ADDR;
            else if (op == OP_SW_RECALL) a = SEQ_RECALL_ADDR;
            else if (op == OP_PLS_OFF) a = SEQ_PLS_OFF; // RULE_24
            else a = SEQ_PLS_ON;
         end
      endcase
      return a;
   endfunction

endpackage
